/* File: hdl/host_cfg_pkg.sv */
// Shared constants for the host bus configuration and select block.
// Assumes a 32-bit AXI4-Lite register slave and 16-bit host I/O addresses.
package host_cfg_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_EXT_ENABLE = 8'h00;
    localparam logic [7:0] OFS_ENABLE_B = 8'h04;
    localparam logic [7:0] OFS_MISC_OUT = 8'h08;
    localparam logic [7:0] OFS_PIN_DEF = 8'h0c;
    localparam logic [7:0] OFS_CLK_CFG = 8'h10;
    localparam logic [7:0] OFS_SWITCH_STAT = 8'h14;
    localparam logic [7:0] OFS_STRAP_CFG = 8'h18;
    // ==========================================================
    // Field positions
    localparam int EN_BIT = 0;
    localparam int ID_LSB = 4;
    localparam int MISC_CLK_LSB = 2;
    localparam int GPO_LSB = 0;
    localparam int CLK_EXT_BIT = 0;
    localparam int ALT_PAL_BIT = 1;
    localparam int MEM_CFG_LSB = 2;
    localparam int STAT_ISA_BIT = 3;
    localparam int STAT_SEL_BIT = 4;
    // ==========================================================
    // Field encodings
    localparam logic [1:0] GPO_HIZ = 2'h0;
    localparam logic [1:0] GPO_LOW = 2'h1;
    localparam logic [1:0] GPO_HIGH = 2'h2;
    localparam logic [1:0] MEM_256K = 2'h0;
    localparam logic [1:0] MEM_1M = 2'h1;
    localparam logic [1:0] MEM_512K = 2'h2;
    localparam logic [1:0] CLK_SEL_A = 2'h0;
    localparam logic [1:0] CLK_SEL_B = 2'h1;
    localparam logic [1:0] CLK_SEL_C = 2'h2;
    localparam logic [2:0] ISA_ID_MASK = 3'h7;
    localparam logic [2:0] MC_ID_MASK = 3'h3;
    localparam logic [2:0] STRAP_RESET = 3'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ==========================================================
    // Host I/O ports
    localparam logic [15:0] PAL_FIRST = 16'h03c6;
    localparam logic [15:0] PAL_LAST = 16'h03c9;
    localparam logic [15:0] PAL_ALT_FIRST = 16'h83c6;
    localparam logic [15:0] PAL_ALT_LAST = 16'h83c9;
    localparam logic [15:0] HOST_STATUS_PORT = 16'h03d7;
    // ==========================================================
    // Pin synchroniser width and idle levels
    localparam int SYNC_W = 24;
    localparam logic [23:0] SYNC_IDLE = 24'h7e0000;
endpackage

/* File: hdl/palette_if.sv */
// Carrier between the host cycle logic and the palette port decoder.
// Assumes both ends sit on the same clock; the interface holds no state.
`timescale 1ns/100ps
interface palette_if;
    logic [15:0] addr;
    logic io_rd;
    logic io_wr;
    logic alt_en;
    logic pal_rd;
    logic pal_wr;
    modport core (output addr, io_rd, io_wr, alt_en, input pal_rd, pal_wr);
    modport decode (input addr, io_rd, io_wr, alt_en, output pal_rd, pal_wr);
endinterface

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser for the host bus pins.
// Assumes the inputs are asynchronous to aclk; idle levels come in as RST_VAL.
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_state_t;

    sync_state_t st_reg;
    sync_state_t st_next;

    // ==========================================================
    // Shift chain; only the second stage is read
    always_comb begin
        st_next = st_reg;
        st_next.stage1 = d;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= {RST_VAL, RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.stage2;
endmodule

/* File: hdl/palette_decode.sv */
// Palette DAC port decoder: standard and alternate port windows.
// Assumes qualified I/O strobes; gives combinational strobes back.
`timescale 1ns/100ps
module palette_decode (
    // Host cycle in, palette strobes out
    palette_if.decode p
);
    logic in_std;
    logic in_alt;

    // ==========================================================
    // Window compare and strobe generation
    always_comb begin
        in_std = (p.addr >= host_cfg_pkg::PAL_FIRST) && (p.addr <= host_cfg_pkg::PAL_LAST);
        in_alt = p.alt_en && (p.addr >= host_cfg_pkg::PAL_ALT_FIRST)
            && (p.addr <= host_cfg_pkg::PAL_ALT_LAST);
    end

    assign p.pal_rd = (in_std || in_alt) && p.io_rd;
    assign p.pal_wr = (in_std || in_alt) && p.io_wr;
endmodule

/* File: hdl/host_bus_config_select.sv */
// Host bus configuration and board select logic of a display controller.
// Assumes an AXI4-Lite master on aclk and asynchronous host bus pins.
`timescale 1ns/100ps
module host_bus_config_select (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Host bus pins in
    input wire logic bus_reset,
    input wire logic [15:0] host_addr,
    input wire logic strap_switch_bit0,
    input wire logic strap_switch_bit1,
    input wire logic strap_switch_bit2,
    input wire logic io_read_n,
    input wire logic io_write_n,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    // Host bus responses
    output logic [15:0] host_data_out,
    output logic [1:0] host_data_oe,
    output logic ready_out,
    output logic ready_oe,
    output logic io_size16_n_out,
    output logic io_size16_n_oe,
    // Palette strobes
    output logic palette_read_n,
    output logic palette_write_n,
    // Clock pins
    input wire logic dot_clock_input_a,
    input wire logic dot_clock_input_b,
    input wire logic dot_clock_input_c,
    output logic ext_clock_mux_sel_low,
    output logic ext_clock_mux_sel_low_oe,
    output logic ext_clock_mux_sel_high,
    output logic ext_clock_mux_sel_high_oe,
    output logic dot_clock_out,
    // General output and status
    output logic general_output_pin,
    output logic general_output_pin_oe,
    output logic [1:0] display_mem_config,
    output logic bus_is_isa,
    output logic board_selected
);
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic enable_a;
        logic enable_b;
        logic [2:0] board_id;
        logic [1:0] misc_clk_sel;
        logic [1:0] gpo_mode;
        logic ext_clk_mode;
        logic alt_pal_en;
        logic [1:0] mem_cfg;
        logic [2:0] strap;
        logic [2:0] switches;
        logic bus_reset_d;
        logic [15:0] host_rdata;
        logic [1:0] host_oe;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [23:0] sync_q;
    logic bus_rst_s;
    logic [15:0] addr_s;
    logic [2:0] sw_s;
    logic ior_s_n;
    logic iow_s_n;
    logic memr_s_n;
    logic memw_s_n;
    logic isa;
    logic io_rd;
    logic io_wr;
    logic board_match;
    logic ext_ok;
    logic [2:0] id_mask;

    palette_if pif ();

    // ==========================================================
    // Pin synchronisers
    pin_sync #(
        .W(host_cfg_pkg::SYNC_W),
        .RST_VAL(host_cfg_pkg::SYNC_IDLE)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({bus_reset, mem_write_n, mem_read_n, io_write_n, io_read_n,
            strap_switch_bit1, strap_switch_bit0, strap_switch_bit2, host_addr}),
        .q(sync_q)
    );

    // Synchronised pin fields
    assign addr_s = sync_q[15:0];
    assign sw_s = {sync_q[16], sync_q[18], sync_q[17]};
    assign ior_s_n = sync_q[19];
    assign iow_s_n = sync_q[20];
    assign memr_s_n = sync_q[21];
    assign memw_s_n = sync_q[22];
    assign bus_rst_s = sync_q[23];

    // ==========================================================
    // Host cycle qualification and board select
    always_comb begin
        isa = st_reg.strap[0];
        if (isa) begin
            io_rd = !ior_s_n && !sw_s[0];
            io_wr = !iow_s_n && !sw_s[0];
            id_mask = host_cfg_pkg::ISA_ID_MASK;
        end else begin
            io_rd = !ior_s_n && !iow_s_n && !memr_s_n && memw_s_n;
            io_wr = !ior_s_n && !iow_s_n && memr_s_n && !memw_s_n;
            id_mask = host_cfg_pkg::MC_ID_MASK;
        end
        board_match = ((st_reg.board_id ^ st_reg.strap) & id_mask) == 3'h0;
        ext_ok = st_reg.enable_a && st_reg.enable_b;
    end

    // Palette decode, gated by board match
    assign pif.addr = addr_s;
    assign pif.io_rd = io_rd && board_match;
    assign pif.io_wr = io_wr && board_match;
    assign pif.alt_en = st_reg.alt_pal_en;

    palette_decode u_pal (
        .p(pif.decode)
    );

    // ==========================================================
    // Next state: AXI slave, registers, strap and host responses
    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        st_next = st_reg;
        // Write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Register write once both halves are held
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = host_cfg_pkg::RESP_OKAY;
            unique case (st_reg.aw_addr)
                host_cfg_pkg::OFS_EXT_ENABLE: begin
                    if (st_reg.w_strb[0]) begin
                        st_next.enable_a = st_reg.w_data[host_cfg_pkg::EN_BIT];
                        st_next.board_id = st_reg.w_data[host_cfg_pkg::ID_LSB +: 3];
                    end
                end
                host_cfg_pkg::OFS_ENABLE_B: begin
                    if (st_reg.w_strb[0]) begin
                        st_next.enable_b = st_reg.w_data[host_cfg_pkg::EN_BIT];
                    end
                end
                host_cfg_pkg::OFS_MISC_OUT: begin
                    // Standard register keeps only its clock select field
                    if (st_reg.w_strb[0]) begin
                        st_next.misc_clk_sel = st_reg.w_data[host_cfg_pkg::MISC_CLK_LSB +: 2];
                    end
                end
                host_cfg_pkg::OFS_PIN_DEF: begin
                    if (st_reg.w_strb[0] && ext_ok) begin
                        st_next.gpo_mode = st_reg.w_data[host_cfg_pkg::GPO_LSB +: 2];
                    end
                end
                host_cfg_pkg::OFS_CLK_CFG: begin
                    if (st_reg.w_strb[0] && ext_ok) begin
                        st_next.ext_clk_mode = st_reg.w_data[host_cfg_pkg::CLK_EXT_BIT];
                        st_next.alt_pal_en = st_reg.w_data[host_cfg_pkg::ALT_PAL_BIT];
                        // Unsupported memory code leaves the size unchanged
                        if (st_reg.w_data[host_cfg_pkg::MEM_CFG_LSB +: 2] != 2'h3) begin
                            st_next.mem_cfg = st_reg.w_data[host_cfg_pkg::MEM_CFG_LSB +: 2];
                        end
                    end
                end
                host_cfg_pkg::OFS_SWITCH_STAT, host_cfg_pkg::OFS_STRAP_CFG: begin
                    st_next.bresp = host_cfg_pkg::RESP_OKAY;
                end
                default: begin
                    st_next.bresp = host_cfg_pkg::RESP_DECERR;
                end
            endcase
        end
        // Register read
        unique case (s_axi_araddr)
            host_cfg_pkg::OFS_EXT_ENABLE:
                rd = {25'h0, st_reg.board_id, 3'h0, st_reg.enable_a};
            host_cfg_pkg::OFS_ENABLE_B: rd = {31'h0, st_reg.enable_b};
            host_cfg_pkg::OFS_MISC_OUT: rd = {28'h0, st_reg.misc_clk_sel, 2'h0};
            host_cfg_pkg::OFS_PIN_DEF: rd = {30'h0, st_reg.gpo_mode};
            host_cfg_pkg::OFS_CLK_CFG:
                rd = {28'h0, st_reg.mem_cfg, st_reg.alt_pal_en, st_reg.ext_clk_mode};
            host_cfg_pkg::OFS_SWITCH_STAT:
                rd = {27'h0, board_match, isa, st_reg.switches};
            host_cfg_pkg::OFS_STRAP_CFG: rd = {29'h0, st_reg.strap};
            default: rd = 32'h0000_0000;
        endcase
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd;
            st_next.rresp = (s_axi_araddr > host_cfg_pkg::OFS_STRAP_CFG
                || s_axi_araddr[1:0] != 2'h0) ? host_cfg_pkg::RESP_DECERR
                : host_cfg_pkg::RESP_OKAY;
        end
        // Switch capture while the command strobe is low
        if (!ior_s_n) begin
            st_next.switches = sw_s;
        end
        // Host read of the status port, byte lanes by transfer width
        st_next.host_rdata = {11'h0, board_match, isa, st_reg.switches};
        if (io_rd && board_match && addr_s == host_cfg_pkg::HOST_STATUS_PORT) begin
            st_next.host_oe = {!sw_s[1], 1'b1};
        end else begin
            st_next.host_oe = 2'h0;
        end
        // Strap latch at the falling edge of bus reset
        st_next.bus_reset_d = bus_rst_s;
        if (!bus_rst_s && st_reg.bus_reset_d) begin
            st_next.strap = sw_s;
        end
        // Bus reset clears register configuration, captured switches and host enables, not the straps
        if (bus_rst_s) begin
            st_next.enable_a = 1'b0;
            st_next.enable_b = 1'b0;
            st_next.board_id = 3'h0;
            st_next.misc_clk_sel = host_cfg_pkg::CLK_SEL_A;
            st_next.gpo_mode = host_cfg_pkg::GPO_HIZ;
            st_next.ext_clk_mode = 1'b0;
            st_next.alt_pal_en = 1'b0;
            st_next.mem_cfg = host_cfg_pkg::MEM_256K;
            st_next.switches = 3'h0;
            st_next.host_oe = 2'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.strap <= host_cfg_pkg::STRAP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // AXI handshake and response outputs
    assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_held && !st_reg.bvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    // Host bus responses, silent unless this board is selected
    assign host_data_out = st_reg.host_rdata;
    assign host_data_oe = st_reg.host_oe;
    assign ready_out = 1'b1;
    assign ready_oe = board_match && (io_rd || io_wr);
    assign io_size16_n_out = 1'b0;
    assign io_size16_n_oe = board_match && (io_rd || io_wr) && !sw_s[1];
    assign palette_read_n = !pif.pal_rd;
    assign palette_write_n = !pif.pal_wr;

    // ==========================================================
    // Dot clock selection, internal or external mux
    always_comb begin
        if (st_reg.ext_clk_mode) begin
            dot_clock_out = dot_clock_input_a;
        end else begin
            unique case (st_reg.misc_clk_sel)
                host_cfg_pkg::CLK_SEL_B: dot_clock_out = dot_clock_input_b;
                host_cfg_pkg::CLK_SEL_C: dot_clock_out = dot_clock_input_c;
                default: dot_clock_out = dot_clock_input_a;
            endcase
        end
    end

    assign ext_clock_mux_sel_low = st_reg.misc_clk_sel[0];
    assign ext_clock_mux_sel_high = st_reg.misc_clk_sel[1];
    assign ext_clock_mux_sel_low_oe = st_reg.ext_clk_mode;
    assign ext_clock_mux_sel_high_oe = st_reg.ext_clk_mode;

    // General output, ISA mode only
    assign general_output_pin = (st_reg.gpo_mode == host_cfg_pkg::GPO_HIGH);
    assign general_output_pin_oe = isa && ((st_reg.gpo_mode == host_cfg_pkg::GPO_LOW)
        || (st_reg.gpo_mode == host_cfg_pkg::GPO_HIGH));
    assign display_mem_config = st_reg.mem_cfg;
    assign bus_is_isa = isa;
    assign board_selected = board_match;

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_ext_off: assert property (bus_rst_s |=> !st_reg.enable_a && !st_reg.enable_b
        && st_reg.gpo_mode == host_cfg_pkg::GPO_HIZ && !st_reg.ext_clk_mode)
        else $error("extension state not cleared by bus reset");
    a_ext_write_gate: assert property (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid
        && st_reg.aw_addr == host_cfg_pkg::OFS_PIN_DEF && !ext_ok && !bus_rst_s
        |=> $stable(st_reg.gpo_mode))
        else $error("extension write took effect while locked");
    a_strap_latch: assert property (!bus_rst_s && st_reg.bus_reset_d
        |=> st_reg.strap == $past(sw_s) ##1 bus_is_isa == $past(sw_s[0], 2))
        else $error("strap not latched at end of bus reset");
    a_switch_capture: assert property (!ior_s_n && !bus_rst_s
        |=> st_reg.switches == $past(sw_s))
        else $error("switch levels not captured under command strobe");
    a_aen_ignored: assert property (isa && sw_s[0] |-> !pif.pal_rd && !pif.pal_wr
        && !ready_oe && !io_size16_n_oe)
        else $error("strobe honoured during DMA cycle");
    a_mismatch_quiet: assert property (!board_match
        |-> !ready_oe && !io_size16_n_oe && palette_read_n ##1 host_data_oe == 2'h0)
        else $error("unselected board answered");
    a_gpo_channel_off: assert property (!isa |-> !general_output_pin_oe)
        else $error("general output driven in channel mode");
    a_gpo_low_drive: assert property (isa && st_reg.gpo_mode == host_cfg_pkg::GPO_LOW
        |-> general_output_pin_oe && !general_output_pin)
        else $error("general output not driven low");
    a_ext_clock_path: assert property (st_reg.ext_clk_mode
        |-> dot_clock_out == dot_clock_input_a && ext_clock_mux_sel_low_oe)
        else $error("external clock mode not using clock a");
    a_palette_range: assert property (pif.pal_wr |-> (addr_s >= host_cfg_pkg::PAL_FIRST
        && addr_s <= host_cfg_pkg::PAL_LAST) || (st_reg.alt_pal_en
        && addr_s >= host_cfg_pkg::PAL_ALT_FIRST))
        else $error("palette strobe outside palette ports");
endmodule

/* File: bench/host_io_model.sv */
// Host bus model: drives ISA style I/O cycles onto the host pins.
// Assumes the bench calls its tasks right after a rising aclk edge.
`timescale 1ns/100ps
module host_io_model (
    // Clock
    input wire logic aclk,
    // Host pins
    output logic [15:0] host_addr,
    output logic [2:0] sw,
    output logic io_read_n,
    output logic io_write_n,
    output logic dac_wide_mode
);
    // ==========================================================
    // Idle bus at time zero, palette left in narrow mode
    initial {host_addr, sw, io_read_n, io_write_n} = {16'hffff, 3'h1, 2'h3};
    assign dac_wide_mode = 1'b0;
    // Start a cycle; the strobe stays low until done
    task start(input logic [15:0] a, input logic [2:0] s, input logic wr);
        @(posedge aclk);
        host_addr <= a;
        sw <= s;
        io_read_n <= wr;
        io_write_n <= !wr;
        repeat (4) @(posedge aclk);
    endtask
    // Release; a floating address shows its inverse
    task done();
        host_addr <= ~host_addr;
        sw <= 3'h1;
        io_read_n <= 1'b1;
        io_write_n <= 1'b1;
        @(posedge aclk);
    endtask
endmodule

/* File: bench/tb_host_bus_config_select.sv */
// Bench for the host config block: AXI register tests and host I/O cycles.
// Assumes the host bus model is compiled first.
`timescale 1ns/100ps
module tb_host_bus_config_select;
    // ==========================================================
    // Signals, named as the ports they feed, except dclk and sw
    logic aclk = 1'b0, aresetn = 1'b0, bus_reset = 1'b0, mem_read_n = 1'b1, mem_write_n = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] dclk = 3'h1, sw;
    logic [15:0] host_addr, host_data_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, host_data_oe, display_mem_config;
    logic io_read_n, io_write_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ready_out, ready_oe, io_size16_n_out, io_size16_n_oe, palette_read_n;
    logic palette_write_n, ext_clock_mux_sel_low, ext_clock_mux_sel_low_oe, ext_clock_mux_sel_high;
    logic ext_clock_mux_sel_high_oe, dot_clock_out, general_output_pin, general_output_pin_oe;
    logic bus_is_isa, board_selected, dac_wide_mode;
    int n_fail = 0;
    int num_checks = 0;
    always #5 aclk = ~aclk;
    // Design and host model
    host_io_model host_u (.aclk, .host_addr, .sw, .io_read_n, .io_write_n, .dac_wide_mode);
    host_bus_config_select dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .bus_reset, .host_addr, .strap_switch_bit0(sw[0]),
        .strap_switch_bit1(sw[1]), .strap_switch_bit2(sw[2]), .io_read_n, .io_write_n,
        .mem_read_n, .mem_write_n, .host_data_out, .host_data_oe, .ready_out, .ready_oe,
        .io_size16_n_out, .io_size16_n_oe, .palette_read_n, .palette_write_n,
        .dot_clock_input_a(dclk[0]), .dot_clock_input_b(dclk[1]), .dot_clock_input_c(dclk[2]),
        .ext_clock_mux_sel_low, .ext_clock_mux_sel_low_oe, .ext_clock_mux_sel_high,
        .ext_clock_mux_sel_high_oe, .dot_clock_out, .general_output_pin, .general_output_pin_oe,
        .display_mem_config, .bus_is_isa, .board_selected);
    // ==========================================================
    // Compare, verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // AXI4-Lite write and read, address and data held until their own ready, response ready held until valid
    task wr(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                {rdat, rrsp} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_arvalid || s_axi_rready);
        @(posedge aclk);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h18);
        chk(rdat, 32'h1);
        chk({31'h0, bus_is_isa}, 32'h1);
        rd(8'h00);
        chk(rdat, 32'h0);
        wr(8'h0c, 32'h2);
        rd(8'h0c);
        chk({rdat[1:0], general_output_pin_oe}, 3'h0);
        wr(8'h00, 32'h11);
        wr(8'h04, 32'h1);
        wr(8'h0c, 32'h2);
        chk({general_output_pin_oe, general_output_pin}, 32'h3);
        wr(8'h0c, 32'h1);
        chk({general_output_pin_oe, general_output_pin}, 32'h2);
        for (int k = 0; k < 4; k++) begin
            dclk <= (k == 1) ? 3'h2 : (k == 2) ? 3'h4 : 3'h1;
            wr(8'h08, 32'(k) << 2);
            chk({31'h0, dot_clock_out}, 32'h1);
        end
        wr(8'h08, 32'hf7);
        rd(8'h08);
        chk(rdat, 32'h4);
        wr(8'h10, 32'h7);
        chk({ext_clock_mux_sel_high_oe, ext_clock_mux_sel_high, ext_clock_mux_sel_low,
            ext_clock_mux_sel_low_oe, dot_clock_out}, 32'h17);
        chk({30'h0, display_mem_config}, 32'h1);
        rd(8'h1c);
        chk({30'h0, rrsp}, 32'h3);
        host_u.start(16'h03c6, 3'h0, 1'b1);
        chk({31'h0, palette_write_n}, 32'h0);
        host_u.done();
        host_u.start(16'h83c7, 3'h0, 1'b1);
        chk({31'h0, palette_write_n}, 32'h0);
        host_u.done();
        host_u.start(16'h03c9, 3'h4, 1'b0);
        chk({31'h0, palette_read_n}, 32'h0);
        host_u.done();
        rd(8'h14);
        chk(rdat, 32'h1c);
        // Status port read with the high byte enabled answers on both lanes
        host_u.start(16'h03d7, 3'h0, 1'b0);
        chk({host_data_oe, ready_oe, io_size16_n_oe, host_data_out[4:3]}, 32'h3f);
        host_u.done();
        host_u.start(16'h03c6, 3'h1, 1'b1);
        chk({31'h0, palette_write_n}, 32'h1);
        host_u.done();
        wr(8'h00, 32'h01);
        chk({31'h0, board_selected}, 32'h0);
        // Bus reset in mid-run: straps relatched, extension state cleared
        bus_reset <= 1'b1;
        host_u.sw <= 3'h5;
        repeat (4) @(posedge aclk);
        bus_reset <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(8'h18);
        chk(rdat, 32'h5);
        rd(8'h10);
        chk(rdat, 32'h0);
        chk({31'h0, general_output_pin_oe}, 32'h0);
        results();
    end
    // Watchdog over far more cycles than the tests need
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule
